// ==== logic/mpe_protect.sv ====
// Parity for level-one words, SEC-DED for level-two memory, CRC engines.
// Assumes a synchronous RAM with one cycle read latency behind the ram_* port.
//
// How it works
// - Level-one data words carry per-byte parity
// - Tag accesses are never parity checked
// - Level-two single errors corrected on read and flagged on l2_sec_out
// - Correction on after reset, off per bank
// - Reported double errors raise a system event
// - Byte and halfword accesses keep check bits consistent
// - Two CRC engines beside the memory DMA
// - CRC covers L1, L2 and external memory words
// - CRC32 over source words, optional data forwarding
// - Signature mismatch against expected raises a fault
`timescale 1ns/1ps
module mpe_protect import mpe_pkg::*; #(
  parameter int N_BANK = N_BANK_DEF,
  parameter int ADDR_W = ADDR_W_DEF,
  parameter int N_CRC = N_CRC_DEF,
  parameter logic [31:0] POLY = CRC_POLY
) (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic l1_gen_in,
  input wire logic [31:0] l1_gen_data_in,
  output logic [3:0] l1_par_out,
  input wire logic l1_chk_in,
  input wire logic l1_tag_in,
  input wire logic [31:0] l1_chk_data_in,
  input wire logic [3:0] l1_chk_par_in,
  output logic l1_perr_out,
  input wire logic l2_req_in,
  input wire logic l2_we_in,
  input wire logic [3:0] l2_be_in,
  input wire logic [ADDR_W-1:0] l2_addr_in,
  input wire logic [31:0] l2_wdata_in,
  output logic l2_ready_out,
  output logic l2_rvalid_out,
  output logic [31:0] l2_rdata_out,
  output logic l2_sec_out,
  output logic l2_ded_event_out,
  input wire logic bank_off_wr_in,
  input wire logic [N_BANK-1:0] bank_off_in,
  input wire logic ded_report_en_in,
  output logic ram_en_out,
  output logic ram_we_out,
  output logic [ADDR_W-1:0] ram_addr_out,
  output logic [CODE_W-1:0] ram_wdata_out,
  input wire logic [CODE_W-1:0] ram_rdata_in,
  input wire logic [N_CRC-1:0] crc_init_in,
  input wire logic [N_CRC-1:0] crc_valid_in,
  input wire logic [N_CRC-1:0][31:0] crc_data_in,
  input wire logic [N_CRC-1:0] crc_fwd_en_in,
  input wire logic [N_CRC-1:0] crc_check_in,
  input wire logic [N_CRC-1:0][31:0] crc_exp_in,
  output logic [N_CRC-1:0][31:0] crc_value_out,
  output logic [N_CRC-1:0] crc_fwd_valid_out,
  output logic [N_CRC-1:0][31:0] crc_fwd_data_out,
  output logic [N_CRC-1:0] crc_fault_out
);

  localparam int BANK_W = $clog2(N_BANK);

  if (N_BANK < 2 || (1 << BANK_W) != N_BANK || ADDR_W <= BANK_W || N_CRC < 1) begin : g_chk
    $error("mpe_protect: unsupported bank count, address width or engine count");
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    mpe_phase_t phase;
    logic we;
    logic [3:0] be;
    logic [ADDR_W-1:0] addr;
    logic [31:0] wdata;
    logic ram_en;
    logic ram_we;
    logic [ADDR_W-1:0] ram_addr;
    logic [CODE_W-1:0] ram_wd;
    logic rvalid;
    logic [31:0] rdata;
    logic sec;
    logic ded_evt;
    logic [N_BANK-1:0] off;
    logic [3:0] l1_par;
    logic l1_perr;
    logic [N_CRC-1:0][31:0] crc;
    logic [N_CRC-1:0] fwd_v;
    logic [N_CRC-1:0][31:0] fwd_d;
    logic [N_CRC-1:0] fault;
  } mpe_state_t;

  mpe_state_t s_ff;
  mpe_state_t nxt_s;
  logic [5:0] syn;
  logic ovr;
  logic dec_off;
  logic dec_single;
  logic dec_double;
  logic [31:0] fixed;
  logic [31:0] merged;

  // ----------------------------------------------------------------
  // Level-two decode of the word now on ram_rdata_in
  // ----------------------------------------------------------------
  always_comb begin
    syn = mpe_ham(ram_rdata_in[31:0]) ^ ram_rdata_in[37:32];
    ovr = (^ram_rdata_in[31:0]) ^ (^ram_rdata_in[38:32]);
    dec_off = s_ff.off[s_ff.addr[ADDR_W-1 -: BANK_W]];
    dec_single = !dec_off && ovr;
    dec_double = !dec_off && !ovr && (syn != 6'h00);
    fixed = ram_rdata_in[31:0];
    for (int j = 0; j < DATA_W; j++) begin
      if (dec_single && mpe_pos(j) == syn) fixed[j] = !fixed[j];
    end
    for (int b = 0; b < 4; b++) begin
      merged[8 * b +: 8] = s_ff.be[b] ? s_ff.wdata[8 * b +: 8] : fixed[8 * b +: 8];
    end
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_s = s_ff;
    nxt_s.ram_en = 1'b0;
    nxt_s.ram_we = 1'b0;
    nxt_s.rvalid = 1'b0;
    nxt_s.sec = 1'b0;
    nxt_s.ded_evt = 1'b0;
    nxt_s.l1_perr = 1'b0;
    if (bank_off_wr_in) nxt_s.off = bank_off_in;
    if (l1_gen_in) nxt_s.l1_par = mpe_bpar(l1_gen_data_in);
    if (l1_chk_in && !l1_tag_in) begin
      nxt_s.l1_perr = mpe_bpar(l1_chk_data_in) != l1_chk_par_in;
    end
    unique case (s_ff.phase)
      PH_IDLE: begin
        if (l2_req_in) begin
          nxt_s.we = l2_we_in;
          nxt_s.be = l2_be_in;
          nxt_s.addr = l2_addr_in;
          nxt_s.wdata = l2_wdata_in;
          nxt_s.ram_en = 1'b1;
          nxt_s.ram_addr = l2_addr_in;
          if (l2_we_in && l2_be_in == BE_FULL) begin
            nxt_s.ram_we = 1'b1;
            nxt_s.ram_wd = {mpe_encode(l2_wdata_in), l2_wdata_in};
          end else begin
            nxt_s.phase = PH_RAMRD;
          end
        end
      end
      PH_RAMRD: nxt_s.phase = PH_DEC;
      PH_DEC: begin
        nxt_s.phase = PH_IDLE;
        nxt_s.sec = dec_single;
        nxt_s.ded_evt = dec_double && ded_report_en_in;
        if (s_ff.we) begin
          nxt_s.ram_en = 1'b1;
          nxt_s.ram_we = 1'b1;
          nxt_s.ram_wd = {mpe_encode(merged), merged};
        end else begin
          nxt_s.rvalid = 1'b1;
          nxt_s.rdata = fixed;
        end
      end
    endcase
    for (int i = 0; i < N_CRC; i++) begin
      logic [31:0] base;
      base = crc_init_in[i] ? CRC_SEED : s_ff.crc[i];
      nxt_s.fwd_v[i] = crc_valid_in[i] && crc_fwd_en_in[i];
      nxt_s.fault[i] = crc_check_in[i] && (s_ff.crc[i] != crc_exp_in[i]);
      if (crc_valid_in[i]) begin
        nxt_s.crc[i] = mpe_crc(base, crc_data_in[i], POLY);
        nxt_s.fwd_d[i] = crc_data_in[i];
      end else begin
        nxt_s.crc[i] = base;
      end
    end
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign l2_ready_out = s_ff.phase == PH_IDLE;
  assign l2_rvalid_out = s_ff.rvalid;
  assign l2_rdata_out = s_ff.rdata;
  assign l2_sec_out = s_ff.sec;
  assign l2_ded_event_out = s_ff.ded_evt;
  assign ram_en_out = s_ff.ram_en;
  assign ram_we_out = s_ff.ram_we;
  assign ram_addr_out = s_ff.ram_addr;
  assign ram_wdata_out = s_ff.ram_wd;
  assign l1_par_out = s_ff.l1_par;
  assign l1_perr_out = s_ff.l1_perr;
  assign crc_value_out = s_ff.crc;
  assign crc_fwd_valid_out = s_ff.fwd_v;
  assign crc_fwd_data_out = s_ff.fwd_d;
  assign crc_fault_out = s_ff.fault;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);

  l1_par_gen_a: assert property (l1_gen_in |=> l1_par_out == mpe_bpar($past(l1_gen_data_in)))
    else $error("L1 parity not generated from written word");
  l1_perr_a: assert property (l1_chk_in && !l1_tag_in && mpe_bpar(l1_chk_data_in) != l1_chk_par_in
    |=> l1_perr_out)
    else $error("L1 parity mismatch not flagged");
  l1_tag_skip_a: assert property (l1_chk_in && l1_tag_in |=> !l1_perr_out)
    else $error("Tag access raised a parity error");
  rd_latency_a: assert property (l2_req_in && l2_ready_out && !l2_we_in
    |-> ##3 l2_rvalid_out)
    else $error("Read data not returned three cycles after acceptance");
  sec_bank_on_a: assert property (l2_sec_out |-> !s_ff.off[s_ff.addr[ADDR_W-1 -: BANK_W]])
    else $error("Correction reported on a disabled bank");
  ded_event_a: assert property (s_ff.phase == PH_DEC && dec_double && ded_report_en_in
    |=> l2_ded_event_out)
    else $error("Double error not raised as event");
  ded_gate_a: assert property (l2_ded_event_out |-> $past(ded_report_en_in))
    else $error("Double error event while reporting disabled");
  ram_check_a: assert property (ram_we_out
    |-> ram_wdata_out[38:32] == mpe_encode(ram_wdata_out[31:0]))
    else $error("Stored check bits do not match stored data");
  rmw_write_a: assert property (l2_req_in && l2_ready_out && l2_we_in && l2_be_in != BE_FULL
    |=> ram_en_out && !ram_we_out ##2 ram_we_out)
    else $error("Partial write not done as read-modify-write");
  full_write_a: assert property (l2_req_in && l2_ready_out && l2_we_in && l2_be_in == BE_FULL
    |=> ram_we_out && ram_addr_out == $past(l2_addr_in))
    else $error("Full word write not issued next cycle");

  for (genvar g = 0; g < N_CRC; g++) begin : g_crc_chk
    crc_fault_a: assert property (crc_check_in[g] && crc_value_out[g] != crc_exp_in[g]
      |=> crc_fault_out[g])
      else $error("CRC mismatch not raised as fault");
    crc_fwd_a: assert property (crc_valid_in[g] && crc_fwd_en_in[g]
      |=> crc_fwd_valid_out[g] && crc_fwd_data_out[g] == $past(crc_data_in[g]))
      else $error("CRC source word not forwarded");
    crc_fault_c: cover property (crc_valid_in[g] ##1 crc_check_in[g] ##1 crc_fault_out[g]);
  end

  sec_read_c: cover property (l2_sec_out && l2_rvalid_out);
  ded_event_c: cover property (l2_ded_event_out);
  rmw_c: cover property (l2_req_in && l2_ready_out && l2_we_in && l2_be_in == 4'hC);

endmodule : mpe_protect

// ==== include/mpe_pkg.sv ====
// Shared constants and helpers for the memory protection block.
// Assumes a 32-bit data word and one synchronous clock domain.
package mpe_pkg;

  // ----------------------------------------------------------------
  // Widths and codes
  // ----------------------------------------------------------------
  localparam int DATA_W = 32;
  localparam int HAM_W = 6;
  localparam int CHK_W = 7;
  localparam int CODE_W = 39;
  localparam int L1_PAR_W = 4;
  localparam int N_CRC_DEF = 2;
  localparam int N_BANK_DEF = 4;
  localparam int ADDR_W_DEF = 12;
  localparam logic [3:0] BE_FULL = 4'hF;
  localparam logic [31:0] CRC_POLY = 32'h04C11DB7;
  localparam logic [31:0] CRC_SEED = 32'hFFFFFFFF;

  typedef enum logic [1:0] {PH_IDLE, PH_RAMRD, PH_DEC} mpe_phase_t;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Codeword position of data bit j (positions that are not powers of two)
  function automatic logic [5:0] mpe_pos(input int j);
    logic [5:0] p;
    int cnt;
    p = '0;
    cnt = 0;
    for (int k = 1; k < CODE_W; k++) begin
      if ((k & (k - 1)) != 0) begin
        if (cnt == j) p = 6'(k);
        cnt++;
      end
    end
    return p;
  endfunction : mpe_pos

  function automatic logic [5:0] mpe_ham(input logic [31:0] d);
    logic [5:0] h;
    h = '0;
    for (int j = 0; j < DATA_W; j++) begin
      if (d[j]) h = h ^ mpe_pos(j);
    end
    return h;
  endfunction : mpe_ham

  // Check bits: [6] overall parity, [5:0] Hamming bits
  function automatic logic [6:0] mpe_encode(input logic [31:0] d);
    logic [5:0] h;
    h = mpe_ham(d);
    return {(^d) ^ (^h), h};
  endfunction : mpe_encode

  function automatic logic [3:0] mpe_bpar(input logic [31:0] d);
    logic [3:0] p;
    for (int i = 0; i < L1_PAR_W; i++) p[i] = ^d[8 * i +: 8];
    return p;
  endfunction : mpe_bpar

  // One 32-bit word into the CRC, MSB first, no reflection
  function automatic logic [31:0] mpe_crc(input logic [31:0] c_in, input logic [31:0] d,
                                          input logic [31:0] poly);
    logic [31:0] c;
    logic fb;
    c = c_in;
    for (int i = DATA_W - 1; i >= 0; i--) begin
      fb = c[31] ^ d[i];
      c = {c[30:0], 1'b0} ^ (fb ? poly : 32'h00000000);
    end
    return c;
  endfunction : mpe_crc

endpackage : mpe_pkg

// ==== test/mpe_ram_model.sv ====
// RAM model behind the level-two port of the protection block.
// Assumes one cycle read latency; the bench sets a bit flip mask.
`timescale 1ns/1ps
module mpe_ram_model import mpe_pkg::*; #(
  parameter int ADDR_W = ADDR_W_DEF
) (
  input wire logic clock_in,
  input wire logic ram_en_in,
  input wire logic ram_we_in,
  input wire logic [ADDR_W-1:0] ram_addr_in,
  input wire logic [CODE_W-1:0] ram_wdata_in,
  input wire logic [CODE_W-1:0] flip_in,
  output logic [CODE_W-1:0] ram_rdata_out
);
  logic [CODE_W-1:0] mem [2**ADDR_W];
  initial ram_rdata_out = '0;
  always @(posedge clock_in) begin
    if (ram_en_in && ram_we_in) begin
      mem[ram_addr_in] <= ram_wdata_in;
    end
    if (ram_en_in && !ram_we_in) begin
      ram_rdata_out <= mem[ram_addr_in] ^ flip_in;
    end else begin
      // Data does not hold once the read cycle is over
      ram_rdata_out <= ~ram_rdata_out;
    end
  end
endmodule : mpe_ram_model

// ==== test/mpe_protect_test.sv ====
// Bench for the protection block: L1 parity, L2 SEC-DED, CRC engines.
// Assumes default parameters and the RAM model on the ram_* port.
`timescale 1ns/1ps
module mpe_protect_test import mpe_pkg::*; ;
  logic clock_in, rst_in, l1_gen_in, l1_chk_in, l1_tag_in, l1_perr_out, l2_req_in, l2_we_in;
  logic l2_ready_out, l2_rvalid_out, l2_sec_out, l2_ded_event_out, bank_off_wr_in;
  logic ded_report_en_in, ram_en_out, ram_we_out;
  logic [3:0] l1_par_out, l1_chk_par_in, l2_be_in, bank_off_in;
  logic [31:0] l1_gen_data_in, l1_chk_data_in, l2_wdata_in, l2_rdata_out;
  logic [11:0] l2_addr_in, ram_addr_out;
  logic [CODE_W-1:0] ram_wdata_out, ram_rdata_in, flip;
  logic [1:0] crc_init_in, crc_valid_in, crc_fwd_en_in, crc_check_in, crc_fwd_valid_out;
  logic [1:0] crc_fault_out;
  logic [1:0][31:0] crc_data_in, crc_exp_in, crc_value_out, crc_fwd_data_out;
  int fail_count;
  int tests_run;

  mpe_protect i_mpe_protect (.clock_in, .rst_in, .l1_gen_in, .l1_gen_data_in, .l1_par_out,
    .l1_chk_in, .l1_tag_in, .l1_chk_data_in, .l1_chk_par_in, .l1_perr_out, .l2_req_in,
    .l2_we_in, .l2_be_in, .l2_addr_in, .l2_wdata_in, .l2_ready_out, .l2_rvalid_out,
    .l2_rdata_out, .l2_sec_out, .l2_ded_event_out, .bank_off_wr_in, .bank_off_in,
    .ded_report_en_in, .ram_en_out, .ram_we_out, .ram_addr_out, .ram_wdata_out,
    .ram_rdata_in, .crc_init_in, .crc_valid_in, .crc_data_in, .crc_fwd_en_in, .crc_check_in,
    .crc_exp_in, .crc_value_out, .crc_fwd_valid_out, .crc_fwd_data_out, .crc_fault_out);
  mpe_ram_model i_mpe_ram_model (.clock_in, .ram_en_in(ram_en_out), .ram_we_in(ram_we_out),
    .ram_addr_in(ram_addr_out), .ram_wdata_in(ram_wdata_out), .flip_in(flip),
    .ram_rdata_out(ram_rdata_in));

  initial begin
    clock_in = 1'b0;
    forever #20 clock_in = ~clock_in;
  end

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] ref_crc(input logic [31:0] c, input logic [31:0] d);
    for (int i = 31; i >= 0; i--) c = {c[30:0], 1'b0} ^ ((c[31] ^ d[i]) ? CRC_POLY : '0);
    return c;
  endfunction : ref_crc

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic close_out();
    $display("Checks %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : close_out

  // Called at a falling edge while the port is idle
  task automatic l2(input logic w, input logic [3:0] b, input logic [11:0] a,
                    input logic [31:0] d);
    {l2_req_in, l2_we_in, l2_be_in, l2_addr_in, l2_wdata_in} = {1'b1, w, b, a, d};
    @(negedge clock_in);
    l2_req_in = 1'b0;
    check(l2_ready_out, w && b == BE_FULL);
    for (int i = 0; i < 6 && !w && l2_rvalid_out !== 1'b1; i++) @(negedge clock_in);
  endtask : l2

  task automatic wr(input logic [3:0] b, input logic [11:0] a, input logic [31:0] d);
    l2(1'b1, b, a, d);
    repeat (4) @(negedge clock_in);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [CODE_W-1:0] f, input logic [31:0] x,
                    input logic es, input logic ed);
    flip = f;
    l2(1'b0, 4'h0, a, 32'h00000000);
    check(l2_rvalid_out, 1'b1);
    check(l2_rdata_out, x);
    check(l2_sec_out, es);
    check(l2_ded_event_out, ed);
    flip = '0;
    @(negedge clock_in);
  endtask : rd

  task automatic bank_set(input logic [3:0] m);
    bank_off_in = m;
    bank_off_wr_in = 1'b1;
    @(negedge clock_in);
    bank_off_wr_in = 1'b0;
  endtask : bank_set

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_l1();
    logic [3:0] p;
    l1_gen_data_in = 32'h800103FF;
    // Bytes 80, 01 odd; 03, FF even: parity bit i follows byte i
    p = 4'b1100;
    l1_gen_in = 1'b1;
    @(negedge clock_in);
    l1_gen_in = 1'b0;
    check(l1_par_out, p);
    {l1_chk_in, l1_chk_data_in} = {1'b1, 32'h800103FF};
    for (int b = 0; b < 4; b++) begin
      l1_chk_par_in = p ^ (4'h1 << b);
      @(negedge clock_in);
      check(l1_perr_out, 1'b1);
    end
    l1_tag_in = 1'b1;
    @(negedge clock_in);
    check(l1_perr_out, 1'b0);
    {l1_tag_in, l1_chk_par_in} = {1'b0, p};
    @(negedge clock_in);
    check(l1_perr_out, 1'b0);
    l1_chk_in = 1'b0;
    $display("Test l1 parity done");
  endtask : t_l1

  task automatic t_ecc();
    wr(4'hF, 12'h010, 32'hCAFE0123);
    rd(12'h010, '0, 32'hCAFE0123, 1'b0, 1'b0);
    for (int b = 0; b < CODE_W; b += 6) rd(12'h010, CODE_W'(1) << b, 32'hCAFE0123, 1'b1, 1'b0);
    ded_report_en_in = 1'b1;
    rd(12'h010, CODE_W'(3) << 32, 32'hCAFE0123, 1'b0, 1'b1);
    ded_report_en_in = 1'b0;
    rd(12'h010, CODE_W'(3) << 32, 32'hCAFE0123, 1'b0, 1'b0);
    $display("Test ecc done");
  endtask : t_ecc

  task automatic t_part();
    wr(4'hF, 12'h020, 32'h11223344);
    wr(4'h2, 12'h020, 32'hAABBCCDD);
    rd(12'h020, '0, 32'h1122CC44, 1'b0, 1'b0);
    wr(4'hC, 12'h020, 32'h5566AABB);
    rd(12'h020, CODE_W'(1) << 37, 32'h5566CC44, 1'b1, 1'b0);
    flip = CODE_W'(1) << 20;
    wr(4'h1, 12'h020, 32'h000000EE);
    rd(12'h020, '0, 32'h5566CCEE, 1'b0, 1'b0);
    $display("Test partial writes done");
  endtask : t_part

  task automatic t_bank();
    bank_set(4'h2);
    wr(4'hF, 12'h400, 32'h0F0F0F0F);
    rd(12'h400, CODE_W'(1), 32'h0F0F0F0E, 1'b0, 1'b0);
    rd(12'h010, CODE_W'(1), 32'hCAFE0123, 1'b1, 1'b0);
    bank_set(4'h0);
    rd(12'h400, CODE_W'(1), 32'h0F0F0F0F, 1'b1, 1'b0);
    $display("Test bank disable done");
  endtask : t_bank

  task automatic t_crc();
    logic [31:0] v;
    crc_fwd_en_in = 2'b01;
    for (int e = 0; e < 2; e++) begin
      {crc_init_in[e], crc_valid_in[e], crc_data_in[e]} = {2'b11, 32'h12345678};
      @(negedge clock_in);
      {crc_init_in[e], crc_data_in[e]} = {1'b0, 32'h9ABCDEF0};
      v = ref_crc(CRC_SEED, 32'h12345678);
      check(crc_value_out[e], v);
      check(crc_fwd_valid_out[e], e == 0);
      if (e == 0) check(crc_fwd_data_out[0], 32'h12345678);
      if (e == 0) check(crc_value_out[1], 32'h00000000);
      @(negedge clock_in);
      v = ref_crc(v, 32'h9ABCDEF0);
      check(crc_value_out[e], v);
      {crc_valid_in[e], crc_check_in[e], crc_exp_in[e]} = {2'b01, v};
      @(negedge clock_in);
      check(crc_fault_out[e], 1'b0);
      crc_exp_in[e] = ~v;
      @(negedge clock_in);
      check(crc_fault_out[e], 1'b1);
      crc_check_in[e] = 1'b0;
    end
    $display("Test crc done");
  endtask : t_crc

  initial begin
    #(3000 * 40);
    fail_count++;
    $display("Error at %0t: watchdog expired", $time);
    close_out();
  end

  initial begin
    {fail_count, tests_run, rst_in} = {32'd0, 32'd0, 1'b1};
    {l1_gen_in, l1_chk_in, l1_tag_in, l2_req_in, l2_we_in, bank_off_wr_in} = '0;
    {ded_report_en_in, crc_init_in, crc_valid_in, crc_fwd_en_in, crc_check_in} = '0;
    {l1_gen_data_in, l1_chk_data_in, l2_wdata_in, l1_chk_par_in, l2_be_in} = '0;
    {bank_off_in, l2_addr_in, flip, crc_data_in, crc_exp_in} = '0;
    repeat (20) @(negedge clock_in);
    rst_in = 1'b0;
    check(l2_ready_out, 1'b1);
    t_l1();
    t_ecc();
    t_part();
    t_bank();
    t_crc();
    close_out();
  end
endmodule : mpe_protect_test
